// ### hdl/watchdog_timer_control.sv
// watchdog timer: AXI4-Lite registers, divider, counter, overflow actions
// assumes aclk is the high-frequency clock and mode inputs are synchronous
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module watchdog_timer_control #(
    parameter int PERIOD_LOG2 = wdt_pkg::PERIOD_LOG2_DEFAULT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [wdt_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [wdt_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stop_mode,
    input wire logic idle_mode,
    input wire logic nmi_accept,
    output logic overflow_nmi,
    output logic wdt_reset_req,
    output logic trap_code_seen
);
    import wdt_pkg::*;

    typedef enum logic {RST_IDLE, RST_ACTIVE} rst_state_t;

    // bus slave state
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [DATA_W-1:0] rdata_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [7:0] wbyte_q;
    logic wlane_q;

    // watchdog control state
    logic cfg_en_q;
    logic active_q;
    logic [1:0] period_q;
    logic action_q;
    logic nmi_q;
    logic trap_q;
    rst_state_t rst_state_q;
    rst_state_t rst_state_d;
    logic [4:0] rst_cnt_q;
    logic rst_req_q;

    // internal nets
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic do_write;
    sel_t wsel;
    sel_t rsel;
    code_t wcode;
    logic cfg_wr;
    logic code_wr;
    logic clear_pulse;
    logic hold;
    logic tick;
    logic overflow;
    logic [BIN_W-1:0] count;

    assign aw_fire = s_axi_awvalid && awready_q;
    assign w_fire = s_axi_wvalid && wready_q;
    assign ar_fire = s_axi_arvalid && arready_q;
    assign do_write = !awready_q && !wready_q && !bvalid_q;
    assign wsel = reg_sel(waddr_q);
    assign rsel = reg_sel(s_axi_araddr);
    assign wcode = decode_code(wbyte_q);
    assign cfg_wr = do_write && wlane_q && (wsel == SEL_CFG);
    assign code_wr = do_write && wlane_q && (wsel == SEL_CODE);
    assign clear_pulse = code_wr && (wcode == CD_CLEAR);
    assign hold = stop_mode || idle_mode;

    // write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            waddr_q <= '0;
        end else if (aw_fire) begin
            awready_q <= 1'b0;
            waddr_q <= s_axi_awaddr;
        end else if (bvalid_q && s_axi_bready) begin
            awready_q <= 1'b1;
        end
    end

    // write data channel, only the low byte lane carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b1;
            wbyte_q <= '0;
            wlane_q <= 1'b0;
        end else if (w_fire) begin
            wready_q <= 1'b0;
            wbyte_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
        end else if (bvalid_q && s_axi_bready) begin
            wready_q <= 1'b1;
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            if (wsel == SEL_CFG || wsel == SEL_CODE) begin
                bresp_q <= RESP_OKAY;
            end else begin
                bresp_q <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else if (ar_fire) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
            case (rsel)
                SEL_CFG: begin
                    rdata_q <= '0;
                end
                SEL_CODE: begin
                    rdata_q <= '0;
                end
                SEL_STATUS: begin
                    rdata_q[ST_ACTION_BIT] <= action_q;
                    rdata_q[ST_PERIOD_LO +: 2] <= period_q;
                    rdata_q[ST_CFG_EN_BIT] <= cfg_en_q;
                    rdata_q[ST_ACTIVE_BIT] <= active_q;
                    rdata_q[ST_NMI_BIT] <= nmi_q;
                    rdata_q[ST_RESET_BIT] <= rst_req_q;
                    rdata_q[ST_COUNT_LO +: BIN_W] <= count;
                end
                default: begin
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // run enable bit as written
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_en_q <= CFG_RESET[CFG_EN_BIT];
        end else if (cfg_wr) begin
            cfg_en_q <= wbyte_q[CFG_EN_BIT];
        end
    end

    // effective run state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_q <= CFG_RESET[CFG_EN_BIT];
        end else if (cfg_wr && wbyte_q[CFG_EN_BIT]) begin
            active_q <= 1'b1;
        end else if (code_wr && wcode == CD_DISABLE && !cfg_en_q) begin
            active_q <= 1'b0;
        end
    end

    // detection period select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_q <= CFG_RESET[CFG_PERIOD_LO +: 2];
        end else if (cfg_wr) begin
            period_q <= wbyte_q[CFG_PERIOD_LO +: 2];
        end
    end

    // overflow action select, one-way to interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            action_q <= CFG_RESET[CFG_ACTION_BIT];
        end else if (cfg_wr) begin
            action_q <= action_q && wbyte_q[CFG_ACTION_BIT];
        end
    end

    // trap enable code recognised, trap logic lives elsewhere
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trap_q <= 1'b0;
        end else begin
            trap_q <= code_wr && (wcode == CD_TRAP);
        end
    end

    wdt_divider #(
        .PERIOD_LOG2(PERIOD_LOG2)
    ) u_divider (
        .aclk(aclk),
        .aresetn(aresetn),
        .hold(hold),
        .period_sel(period_q),
        .tick(tick)
    );

    wdt_bincnt u_bincnt (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .hold(hold),
        .clear(clear_pulse),
        .run(active_q),
        .count(count),
        .overflow(overflow)
    );

    // interrupt latch, set wins over accept, no mask applies
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_q <= 1'b0;
        end else if (overflow && !action_q) begin
            nmi_q <= 1'b1;
        end else if (nmi_accept) begin
            nmi_q <= 1'b0;
        end
    end

    // reset pulse sequencer
    always_comb begin
        rst_state_d = rst_state_q;
        case (rst_state_q)
            RST_IDLE: begin
                if (overflow && action_q) begin
                    rst_state_d = RST_ACTIVE;
                end
            end
            RST_ACTIVE: begin
                if (rst_cnt_q == 5'(RESET_CYCLES - 1)) begin
                    rst_state_d = RST_IDLE;
                end
            end
            default: begin
                rst_state_d = RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_state_q <= RST_IDLE;
        end else begin
            rst_state_q <= rst_state_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_cnt_q <= '0;
        end else if (rst_state_q == RST_ACTIVE) begin
            rst_cnt_q <= rst_cnt_q + 5'(1);
        end else begin
            rst_cnt_q <= '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_req_q <= 1'b0;
        end else begin
            rst_req_q <= (rst_state_d == RST_ACTIVE);
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign overflow_nmi = nmi_q;
    assign wdt_reset_req = rst_req_q;
    assign trap_code_seen = trap_q;

endmodule // watchdog_timer_control

// ### hdl/wdt_bincnt.sv
// two-stage binary counter fed by the divider tick
// assumes clear and run are single-cycle or level controls from the top
`timescale 1ns/100ps
module wdt_bincnt (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic hold,
    input wire logic clear,
    input wire logic run,
    output logic [wdt_pkg::BIN_W-1:0] count,
    output logic overflow
);
    import wdt_pkg::*;

    logic [BIN_W-1:0] cnt_q;
    logic ovf_q;
    logic step;

    assign step = tick && !hold && run && !clear;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
        end else if (clear || !run) begin
            cnt_q <= '0;
        end else if (step) begin
            cnt_q <= cnt_q + BIN_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= step && (cnt_q == {BIN_W{1'b1}});
        end
    end

    assign count = cnt_q;
    assign overflow = ovf_q;

endmodule // wdt_bincnt

// ### hdl/wdt_divider.sv
// internal divider of the watchdog, counts on aclk while hold is low
// assumes hold comes from the power-mode logic, synchronous to aclk
`timescale 1ns/100ps
module wdt_divider #(
    parameter int PERIOD_LOG2 = wdt_pkg::PERIOD_LOG2_DEFAULT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic hold,
    input wire logic [1:0] period_sel,
    output logic tick
);
    import wdt_pkg::*;

    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] mask;
    logic tick_q;

    always_comb begin
        mask = (DIV_W'(1) << tick_shift(period_sel, PERIOD_LOG2)) - DIV_W'(1);
    end

    // divider halts with the mode, never cleared by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= '0;
        end else if (!hold) begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= !hold && ((div_q & mask) == mask);
        end
    end

    assign tick = tick_q;

endmodule // wdt_divider

// ### hdl/wdt_pkg.sv
// constants, types and decode helpers of the watchdog block
// shared by the register top and its divider and counter stages
package wdt_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register map, byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h34;
    localparam logic [ADDR_W-1:0] ADDR_CODE = 8'h38;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h3C;

    // watchdog_config fields
    localparam int CFG_ACTION_BIT = 0;
    localparam int CFG_PERIOD_LO = 1;
    localparam int CFG_EN_BIT = 3;
    localparam logic [7:0] CFG_RESET = 8'h39;

    // watchdog_code_port codes
    localparam logic [7:0] CODE_CLEAR = 8'h4E;
    localparam logic [7:0] CODE_DISABLE = 8'hB1;
    localparam logic [7:0] CODE_TRAP_EN = 8'hD2;

    // status fields
    localparam int ST_ACTION_BIT = 0;
    localparam int ST_PERIOD_LO = 1;
    localparam int ST_CFG_EN_BIT = 3;
    localparam int ST_ACTIVE_BIT = 4;
    localparam int ST_NMI_BIT = 5;
    localparam int ST_RESET_BIT = 6;
    localparam int ST_COUNT_LO = 8;

    // timing: fc is aclk, 4 ns
    localparam int CLK_PERIOD_PS = 4000;
    localparam int RESET_FC_PERIODS = 24;
    localparam int RESET_TIME_PS = RESET_FC_PERIODS * CLK_PERIOD_PS;
    localparam int RESET_CYCLES = RESET_TIME_PS / CLK_PERIOD_PS;
    localparam int PERIOD_LOG2_DEFAULT = 25;
    localparam int BIN_W = 2;
    localparam int DIV_W = 24;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {SEL_CFG, SEL_CODE, SEL_STATUS, SEL_NONE} sel_t;
    typedef enum logic [1:0] {CD_NONE, CD_CLEAR, CD_DISABLE, CD_TRAP} code_t;

    function automatic sel_t reg_sel(input logic [ADDR_W-1:0] a);
        sel_t s;
        s = SEL_NONE;
        if (a[ADDR_W-1:2] == ADDR_CONFIG[ADDR_W-1:2]) s = SEL_CFG;
        if (a[ADDR_W-1:2] == ADDR_CODE[ADDR_W-1:2]) s = SEL_CODE;
        if (a[ADDR_W-1:2] == ADDR_STATUS[ADDR_W-1:2]) s = SEL_STATUS;
        return s;
    endfunction

    function automatic code_t decode_code(input logic [7:0] v);
        code_t c;
        c = CD_NONE;
        if (v == CODE_CLEAR) c = CD_CLEAR;
        if (v == CODE_DISABLE) c = CD_DISABLE;
        if (v == CODE_TRAP_EN) c = CD_TRAP;
        return c;
    endfunction

    // divider tick span: a quarter of the detection period
    function automatic int tick_shift(input logic [1:0] sel, input int base);
        return base - BIN_W - 2 * int'(sel);
    endfunction

endpackage

// ### sim/test_watchdog_timer_control.sv
// self-checking bench of the watchdog block over AXI4-Lite
// assumes PERIOD_LOG2 of 9: detection periods 512, 128, 32 and 8 cycles
`timescale 1ns/100ps
module test_watchdog_timer_control;
    import wdt_pkg::*;
    localparam int PL2 = 9;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic bready = 1'h0, rready = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
    logic stop_m = 1'h0, idle_m = 1'h0, nmi_ack = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, nmi, rst_req, trap;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic nmi_p = 1'h0, rst_p = 1'h0, trap_p = 1'h0;
    int mismatches = 0, total_checks = 0, seed = 32'h28182805;
    logic [31:0] rd_exp_q[$], rd_mask_q[$];
    logic [1:0] rd_resp_q[$], wr_resp_q[$], ev_q[$];
    always #2 aclk = ~aclk;
    watchdog_timer_control #(.PERIOD_LOG2(PL2)) DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .stop_mode(stop_m), .idle_mode(idle_m),
        .nmi_accept(nmi_ack), .overflow_nmi(nmi), .wdt_reset_req(rst_req),
        .trap_code_seen(trap));
    task automatic fail(input string m);
        mismatches++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask
    task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
        total_checks++;
        if (g !== e) fail("response code");
    endtask
    task automatic cmp_data(input logic [31:0] e, m, g);
        total_checks++;
        if ((g & m) !== (e & m)) fail("read data");
    endtask
    task automatic cmp_event(input logic [1:0] e, input logic [1:0] g);
        total_checks++;
        if (g !== e) fail("wrong event kind");
    endtask
    task automatic cmp_flag(input logic e, input logic g);
        total_checks++;
        if (g !== e) fail("flag or timing");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic ev(input logic hit, input logic [1:0] k);
        if (hit !== 1'h1) return;
        if (ev_q.size() == 0) fail("unexpected event");
        else cmp_event(ev_q.pop_front(), k);
    endtask
    // monitor: responses and event edges, sampled when settled
    always @(negedge aclk) begin
        nmi_p <= nmi;
        rst_p <= rst_req;
        trap_p <= trap;
        if (bvalid === 1'h1) cmp_resp(wr_resp_q.pop_front(), bresp);
        if (rvalid === 1'h1) begin
            cmp_resp(rd_resp_q.pop_front(), rresp);
            cmp_data(rd_exp_q.pop_front(), rd_mask_q.pop_front(), rdata);
        end
        ev(nmi && !nmi_p, 2'h0);
        ev(rst_req && !rst_p, 2'h1);
        ev(trap && !trap_p, 2'h2);
    end
    task automatic wr(input logic [7:0] a, d, input logic [1:0] r);
        int n;
        logic aw_hit, w_hit, b_hit;
        n = 0;
        wr_resp_q.push_back(r);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (n < 50) begin
            @(negedge aclk);
            aw_hit = awvalid && (awready === 1'h1);
            w_hit = wvalid && (wready === 1'h1);
            b_hit = (bvalid === 1'h1);
            @(posedge aclk);
            n++;
            if (aw_hit) awvalid <= 1'h0;
            if (w_hit) wvalid <= 1'h0;
            if (b_hit) begin
                bready <= 1'h0;
                n = 99;
            end
        end
        if (n < 99) fail("write timeout");
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
            input logic [1:0] r);
        int n;
        logic ar_hit, r_hit;
        n = 0;
        rd_exp_q.push_back(e);
        rd_mask_q.push_back(m);
        rd_resp_q.push_back(r);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (n < 50) begin
            @(negedge aclk);
            ar_hit = arvalid && (arready === 1'h1);
            r_hit = (rvalid === 1'h1);
            @(posedge aclk);
            n++;
            if (ar_hit) arvalid <= 1'h0;
            if (r_hit) begin
                rready <= 1'h0;
                n = 99;
            end
        end
        if (n < 99) fail("read timeout");
        @(posedge aclk);
    endtask
    task automatic wait_ev(input int lim, output int n);
        n = 0;
        while (ev_q.size() != 0 && n < lim) begin
            @(negedge aclk);
            n++;
        end
        if (ev_q.size() != 0) fail("missing event");
        @(posedge aclk);
    endtask
    task automatic dis;
        wr(ADDR_CODE, CODE_CLEAR, RESP_OKAY);
        wr(ADDR_CONFIG, 8'h00, RESP_OKAY);
        wr(ADDR_CODE, CODE_DISABLE, RESP_OKAY);
    endtask
    task automatic ack;
        nmi_ack <= 1'h1;
        @(posedge aclk);
        nmi_ack <= 1'h0;
        @(posedge aclk);
        cmp_flag(1'h0, nmi);
    endtask
    initial begin
        int n, p;
        logic [7:0] c;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        rd(ADDR_STATUS, 32'h19, 32'h7F, RESP_OKAY);
        rd(ADDR_CONFIG, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
        wstrb <= 4'hE;
        wr(ADDR_CONFIG, 8'h00, RESP_OKAY);
        wstrb <= 4'hF;
        rd(ADDR_STATUS, 32'h19, 32'h1F, RESP_OKAY);
        wr(ADDR_CODE, CODE_DISABLE, RESP_OKAY);
        rd(ADDR_STATUS, 32'h10, 32'h10, RESP_OKAY);
        wr(8'h40, 8'h00, RESP_SLVERR);
        rd(8'h40, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        wr(ADDR_STATUS, 8'h00, RESP_SLVERR);
        c = 8'($random(seed));
        if (c == CODE_CLEAR || c == CODE_DISABLE || c == CODE_TRAP_EN)
            c = c ^ 8'h01;
        wr(ADDR_CODE, c, RESP_OKAY);
        ev_q.push_back(2'h2);
        wr(ADDR_CODE, CODE_TRAP_EN, RESP_OKAY);
        wait_ev(10, n);
        ev_q.push_back(2'h1);
        wait_ev(700, n);
        for (int s = 0; s < 4; s++) begin
            dis();
            rd(ADDR_STATUS, 32'h0, 32'h310, RESP_OKAY);
            ack();
            wr(ADDR_CONFIG, 8'(8 + 2 * s), RESP_OKAY);
            ev_q.push_back(2'h0);
            wait_ev(700, n);
            p = 1 << (PL2 - 2 * s);
            cmp_flag(1'h1, n >= p * 3 / 4 - 4 && n <= p + 4);
        end
        dis();
        ack();
        wr(ADDR_CONFIG, 8'h09, RESP_OKAY);
        rd(ADDR_STATUS, 32'h18, 32'h19, RESP_OKAY);
        wr(ADDR_CODE, CODE_CLEAR, RESP_OKAY);
        n = 300 + ($random(seed) & 63);
        stop_m <= 1'h1;
        repeat (n) @(posedge aclk);
        stop_m <= 1'h0;
        idle_m <= 1'h1;
        repeat (n) @(posedge aclk);
        idle_m <= 1'h0;
        wr(ADDR_CODE, CODE_CLEAR, RESP_OKAY);
        ev_q.push_back(2'h0);
        wait_ev(600, n);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fail("watchdog timeout");
        final_report();
    end
endmodule // test_watchdog_timer_control

// ### sim/watchdog_timer_control_props.sv
// checker of the watchdog block's bus handshakes and overflow outputs
// assumes one clock domain; bound to every watchdog_timer_control
`timescale 1ns/100ps
module watchdog_timer_control_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic stop_mode,
    input wire logic idle_mode,
    input wire logic nmi_accept,
    input wire logic overflow_nmi,
    input wire logic wdt_reset_req,
    input wire logic trap_code_seen
);
    import wdt_pkg::*;
    logic [4:0] rst_cnt_q;
    logic halt;
    assign halt = stop_mode | idle_mode;
    // cycles the reset request has stood so far
    always_ff @(posedge aclk) begin
        if (!aresetn) rst_cnt_q <= 5'h00;
        else if (wdt_reset_req) rst_cnt_q <= rst_cnt_q + 5'h01;
        else rst_cnt_q <= 5'h00;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence resp_due;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    write_resp_a: assert property (wr_taken |=> resp_due)
        else $error("write response late or early");
    wr_stall_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready during response");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    rd_stall_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read ready during read data");
    nmi_latch_a: assert property (overflow_nmi && !nmi_accept |=> overflow_nmi)
        else $error("interrupt dropped before accept");
    nmi_release_a: assert property ($fell(overflow_nmi) |-> $past(nmi_accept))
        else $error("interrupt fell without accept");
    reset_max_a: assert property (wdt_reset_req |-> rst_cnt_q < 5'h18)
        else $error("reset request longer than 24 cycles");
    reset_full_a: assert property ($fell(wdt_reset_req) |-> $past(rst_cnt_q) == 5'h17)
        else $error("reset request not 24 cycles");
    trap_pulse_a: assert property (trap_code_seen |=> !trap_code_seen)
        else $error("trap pulse longer than one cycle");
    stop_freeze_a: assert property (halt && $past(halt) && $past(halt, 2)
        |-> !$rose(overflow_nmi) && !$rose(wdt_reset_req))
        else $error("overflow while halted");
endmodule // watchdog_timer_control_props

bind watchdog_timer_control watchdog_timer_control_props u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .stop_mode(stop_mode),
    .idle_mode(idle_mode), .nmi_accept(nmi_accept),
    .overflow_nmi(overflow_nmi), .wdt_reset_req(wdt_reset_req),
    .trap_code_seen(trap_code_seen));
